// ===== cmp_vref_defines.svh
`ifndef CMP_VREF_DEFINES_SVH
`define CMP_VREF_DEFINES_SVH

// Register word indices. Some printed offsets are not multiples of four,
// so each offset is an index and the APB byte address is four times it.
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPH_IRQ_FLAGS 8'h0c
`define IDX_COMPARATOR_CONTROL 8'h1f
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPH_IRQ_ENABLES 8'h8c
`define IDX_REFERENCE_CONTROL 8'h9f
`define IDX_PORT_A_DATA 8'h05

// Field positions.
`define BIT_CMP_CHANGE 6
`define BIT_SECOND_RESULT 7
`define BIT_FIRST_RESULT 6
`define BIT_CMP_INPUT_SWITCH 3
`define BIT_REF_ENABLE 7
`define BIT_REF_PIN_CONNECT 6
`define BIT_REF_RANGE 5
`define BIT_GLOBAL_IRQ 7
`define BIT_PERIPH_GATE 6

// Reset values.
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_CMP_CONTROL 4'h0
`define RST_PORT_A_DIRECTION 5'h1f
`define RST_REFERENCE_CONTROL 8'h00

// Comparator mode that puts both results on port pins 3 and 4.
`define CMP_MODE_PIN_OUT 3'h6

`endif

// ===== cmp_vref_pkg.sv
package cmp_vref_pkg;

   // Outcome of decoding one APB address.
   typedef enum logic [2:0]
   {
      reg_none = 3'h0,
      reg_interrupt_control = 3'h1,
      reg_flags = 3'h2,
      reg_cmpctl = 3'h3,
      reg_dir = 3'h4,
      reg_enables = 3'h5,
      reg_refctl = 3'h6,
      reg_port = 3'h7
   } reg_sel_t;

endpackage

// ===== cmp_change_detect.sv
`timescale 1ns/1ps

// Synchronises the comparator results and flags any change.
module cmp_change_detect #(
   parameter int width = 2
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Raw results and their synchronised view.
   input wire logic [width-1:0] raw_result,
   output logic [width-1:0] sync_result,
   output logic change_pulse
);

   logic [width-1:0] meta_q;
   logic [width-1:0] sync_q;
   logic [width-1:0] last_q;
   logic [1:0] prime_q;

   if (width < 1)
   begin : g_width_check
      $error("cmp_change_detect needs width of at least one");
   end

   // Two flops per result; the first stage feeds nothing else.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= raw_result;
         sync_q <= meta_q;
      end
   end

   // The history holds a real sample only three edges after reset: two fill
   // the synchroniser and one copies it. Until then no change is reported, so
   // a result that is already high at reset release never looks like a change.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_q <= '0;
         prime_q <= 2'h0;
      end
      else
      begin
         last_q <= sync_q;
         if (prime_q != 2'h3)
         begin
            prime_q <= prime_q + 2'h1;
         end
      end
   end

   assign sync_result = sync_q;
   assign change_pulse = (prime_q == 2'h3) && (sync_q != last_q);

endmodule // cmp_change_detect

// ===== cmp_vref_control.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "cmp_vref_defines.svh"

module cmp_vref_control #(
   parameter int addr_width = 12
) (
   // APB slave.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparators, first in bit 0, second in bit 1.
   input wire logic [1:0] cmp_raw_result,
   // Port A pins 0 to 4: sampled input levels and output path.
   input wire logic [4:0] port_a_pin_in,
   input wire logic [4:0] port_a_latch,
   output logic port_a_pin3_out,
   output logic port_a_pin3_oe,
   output logic port_a_pin4_out,
   output logic port_a_pin4_oe,
   output logic [4:0] port_a_analog,
   // Comparator configuration to the analog side.
   output logic [2:0] cmp_mode_field,
   output logic cmp_input_switch,
   // Reference ladder controls.
   output logic ref_enable,
   output logic ref_pin_connect,
   output logic ref_range_select,
   output logic [3:0] ref_value,
   output logic ref_to_port_a_pin2,
   // Request into the core interrupt logic.
   output logic cmp_irq_request
);

   // Register state. Each register keeps only the bits it implements, except the reference
   // register, which stores bit 4 as zero; the rest of each byte is rebuilt as zero in the read mux.
   logic [7:0] interrupt_control_q;
   logic cmp_change_flag_q;
   logic cmp_change_irq_en_q;
   logic [3:0] cmpctl_q;
   logic [4:0] port_a_direction_q;
   logic [7:0] refctl_q;
   // Synchronised comparator results and the one-cycle change strobe.
   logic [1:0] cmp_sync;
   logic cmp_change;
   // Bus side: read word, its captured copy and the decoded access.
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic access;
   logic wr_en;
   logic wr_lane0;
   cmp_vref_pkg::reg_sel_t sel;
   // Pin path for port A pins 3 and 4, index 0 for pin 3.
   logic cmp_pin_mode;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;

   // The decode reads index bits 9 to 2 and demands zero in the bits above
   // them, so the address needs at least one bit beyond bit 9. A narrower bus
   // would alias the upper register bank onto the lower one.
   if (addr_width < 11)
   begin : g_addr_check
      $error("cmp_vref_control needs addr_width of at least eleven");
   end

   // Address decode; used by both the write and read paths. Each register
   // holds one aligned word, so a byte offset inside the word or any set bit
   // above the index is a miss rather than being folded onto a register.
   // A miss is answered with an error response and never changes state.
   function automatic cmp_vref_pkg::reg_sel_t decode(input logic [addr_width-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      if (a[1:0] != 2'b00 || a[addr_width-1:10] != '0)
      begin
         return cmp_vref_pkg::reg_none;
      end
      unique case (idx)
         `IDX_INTERRUPT_CONTROL: return cmp_vref_pkg::reg_interrupt_control;
         `IDX_PERIPH_IRQ_FLAGS: return cmp_vref_pkg::reg_flags;
         `IDX_COMPARATOR_CONTROL: return cmp_vref_pkg::reg_cmpctl;
         `IDX_PORT_A_DIRECTION: return cmp_vref_pkg::reg_dir;
         `IDX_PERIPH_IRQ_ENABLES: return cmp_vref_pkg::reg_enables;
         `IDX_REFERENCE_CONTROL: return cmp_vref_pkg::reg_refctl;
         `IDX_PORT_A_DATA: return cmp_vref_pkg::reg_port;
         default: return cmp_vref_pkg::reg_none;
      endcase
   endfunction

   // Mask of port A pins the comparator mode makes analog inputs.
   // Mode 7 turns both comparators off and leaves every pin digital; mode 6
   // keeps pins 0 to 2 analog because pins 3 and 4 carry the results; mode 5
   // keeps pins 0 and 1 only; every other mode keeps pins 0 to 3 analog,
   // the safe choice because an analog level on a digital input wastes current.
   function automatic logic [4:0] analog_mask(input logic [2:0] mode);
      unique case (mode)
         3'h7: return 5'h00;
         3'h6: return 5'h07;
         3'h5: return 5'h03;
         default: return 5'h0f;
      endcase
   endfunction

   // Zero wait states: every access completes in its first access cycle.
   // Every register is a flop or a plain mux, so there is nothing to wait for;
   // a slower register added later would need pready driven from its own state.
   // Writes only look at byte lane 0, because every register sits in that byte.
   // An error response still completes at once, so a bad address never hangs the bus.
   assign access = psel && penable;
   assign sel = decode(paddr);
   assign wr_en = access && pwrite;
   assign wr_lane0 = wr_en && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = access && (sel == cmp_vref_pkg::reg_none);

   // The comparator results come from analog circuits with no relation to
   // pclk, so they pass a two-flop synchroniser before the change compare.
   // The register reads and the change flag use the synchronised copy; the
   // pin path of mode 6 uses the raw level on purpose.
   // A result that is already set at reset release is not taken as a change.
   cmp_change_detect #(
      .width(2)
   ) u_change (
      .pclk(pclk),
      .presetn(presetn),
      .raw_result(cmp_raw_result),
      .sync_result(cmp_sync),
      .change_pulse(cmp_change)
   );

   // Global interrupt control is stored here for the core; only its byte is kept.
   // Its global enable and peripheral gate act in the core, not in this block,
   // so the change flag below never looks at them.
   // Its reset value comes from the header, as for the comparator, direction and reference registers; the flag and enable bits reset to zero here.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         interrupt_control_q <= `RST_INTERRUPT_CONTROL;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_interrupt_control)
      begin
         interrupt_control_q <= pwdata[7:0];
      end
   end

   // Change flag: a hardware change wins over a same-cycle software clear.
   // Losing the clear is harmless, since software reads the flag again after
   // clearing it; losing the change would hide an event for good.
   // Neither enable bit takes part here, so the flag records every change.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_change_flag_q <= 1'b0;
      end
      else if (cmp_change)
      begin
         cmp_change_flag_q <= 1'b1;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_flags)
      begin
         cmp_change_flag_q <= pwdata[`BIT_CMP_CHANGE];
      end
   end

   // Interrupt enable bit. It only gates the request; the flag keeps
   // collecting changes while it is clear, so software should clear the flag
   // before it sets this bit.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_change_irq_en_q <= 1'b0;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_enables)
      begin
         cmp_change_irq_en_q <= pwdata[`BIT_CMP_CHANGE];
      end
   end

   // Comparator control: only input switch and mode are writable.
   // The result bits are not stored at all; the read mux takes them straight
   // from the synchroniser, which is why writes to them cannot stick.
   // Bits 5 and 4 do not exist and are dropped with the result bits.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmpctl_q <= `RST_CMP_CONTROL;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_cmpctl)
      begin
         cmpctl_q <= pwdata[3:0];
      end
   end

   // Port A direction, five pins, all inputs after reset.
   // A set bit means input. Starting as inputs keeps every pin from driving
   // against an outside source until software has chosen its use.
   // The upper three bits of the byte are not kept.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_a_direction_q <= `RST_PORT_A_DIRECTION;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_dir)
      begin
         port_a_direction_q <= pwdata[4:0];
      end
   end

   // Reference control. Only presetn clears it; sleep and wake have no path
   // in here, so the contents survive a wake.
   // Software should still turn the reference off before sleep to save current;
   // nothing in this block does that on its own.
   // Bit 4 is forced to zero on every write, so it always reads back as zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         refctl_q <= `RST_REFERENCE_CONTROL;
      end
      else if (wr_lane0 && sel == cmp_vref_pkg::reg_refctl)
      begin
         refctl_q <= {pwdata[7:5], 1'b0, pwdata[3:0]};
      end
   end

   // Read mux; unmapped addresses read zero with an error response.
   // Bits that a register does not implement stay at the zero given at the top,
   // so no mask is needed per register.
   // The mux is only sampled in the setup cycle of a read.
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      unique case (sel)
         cmp_vref_pkg::reg_interrupt_control: rdata_d[7:0] = interrupt_control_q;
         cmp_vref_pkg::reg_flags: rdata_d[`BIT_CMP_CHANGE] = cmp_change_flag_q;
         cmp_vref_pkg::reg_enables: rdata_d[`BIT_CMP_CHANGE] = cmp_change_irq_en_q;
         // Second result in bit 7, first in bit 6, then two unused bits.
         // results read only
         cmp_vref_pkg::reg_cmpctl: rdata_d[7:0] = {cmp_sync[1], cmp_sync[0], 2'b00, cmpctl_q};
         cmp_vref_pkg::reg_dir: rdata_d[4:0] = port_a_direction_q;
         cmp_vref_pkg::reg_refctl: rdata_d[7:0] = refctl_q;
         // Pins 5 and up do not exist and read zero with the rest.
         // analog pins read zero
         cmp_vref_pkg::reg_port: rdata_d[4:0] = port_a_pin_in & ~analog_mask(cmpctl_q[2:0]);
         cmp_vref_pkg::reg_none: rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the setup cycle, so it is stable from a flop.
   // The capture costs nothing in speed because the access cycle follows at
   // once; a master that changed the address between setup and access would
   // break the bus rules and would get the word of the setup address.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         rdata_q <= rdata_d;
      end
   end

   // The bus sees the captured word; it stays put until the next read setup.
   assign prdata = rdata_q;

   // Pins 3 and 4 share one output path. The raw result is used, not the
   // synchronised one, so the pin follows the comparator without delay; the
   // price is that the pin may show a level that the registers have not seen.
   assign cmp_pin_mode = cmpctl_q[2:0] == `CMP_MODE_PIN_OUT;

   for (genvar i = 0; i < 2; i++)
   begin : g_cmp_pin
      assign pin_out[i] = cmp_pin_mode ? cmp_raw_result[i] : port_a_latch[i + 3];
      assign pin_oe[i] = !port_a_direction_q[i + 3];
   end

   // Pin 3 carries the first comparator and pin 4 the second.
   assign port_a_pin3_out = pin_out[0];
   assign port_a_pin4_out = pin_out[1];
   assign port_a_pin3_oe = pin_oe[0];
   assign port_a_pin4_oe = pin_oe[1];
   assign port_a_analog = analog_mask(cmpctl_q[2:0]);

   // Configuration goes to the analog side straight from the registers. The
   // reference and comparator fields come from separate registers, so writing
   // one never disturbs the other.
   assign cmp_mode_field = cmpctl_q[2:0];
   assign cmp_input_switch = cmpctl_q[`BIT_CMP_INPUT_SWITCH];
   assign ref_enable = refctl_q[`BIT_REF_ENABLE];
   assign ref_pin_connect = refctl_q[`BIT_REF_PIN_CONNECT];
   assign ref_range_select = refctl_q[`BIT_REF_RANGE];
   assign ref_value = refctl_q[3:0];

   // The ladder reaches pin 2 only while the pin is an input, so the pin driver
   // never fights the reference; a set direction bit means input.
   // pin 2 connect
   assign ref_to_port_a_pin2 = port_a_direction_q[2] && refctl_q[`BIT_REF_PIN_CONNECT];

   // The request is a level for the core; it falls as soon as software clears
   // either the flag or the enable.
   // enable gates request
   assign cmp_irq_request = cmp_change_flag_q && cmp_change_irq_en_q;

endmodule // cmp_vref_control

// ===== cmp_vref_monitor.sv
`timescale 1ns/1ps

// Watches pin muxing, reference register and interrupt gating at the ports.
module cmp_vref_monitor #(
   parameter int addr_width = 12
) (
   // Clock, reset and bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   // Pins and controls.
   input wire logic [1:0] cmp_raw_result,
   input wire logic [4:0] port_a_latch,
   input wire logic port_a_pin3_out,
   input wire logic port_a_pin3_oe,
   input wire logic port_a_pin4_out,
   input wire logic [2:0] cmp_mode_field,
   input wire logic ref_enable,
   input wire logic ref_pin_connect,
   input wire logic ref_range_select,
   input wire logic [3:0] ref_value,
   input wire logic ref_to_port_a_pin2,
   input wire logic cmp_irq_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A write lands only with byte lane 0 enabled, so the decode includes it.
   logic wr_ok;
   assign wr_ok = psel && penable && pwrite && pready && pstrb[0];

   AST_PIN3_MUX: assert property (
      cmp_mode_field == 3'h6 |-> port_a_pin3_out == cmp_raw_result[0])
      else $error("pin 3 does not carry the first result");
   AST_PIN4_MUX: assert property (
      cmp_mode_field == 3'h6 |-> port_a_pin4_out == cmp_raw_result[1])
      else $error("pin 4 does not carry the second result");
   AST_LATCH_PATH: assert property (
      cmp_mode_field != 3'h6 |-> port_a_pin4_out == port_a_latch[4])
      else $error("pin 4 left the latch path");
   AST_OE_DIR: assert property (
      wr_ok && paddr == 12'h214 |=> port_a_pin3_oe == !$past(pwdata[3]))
      else $error("pin 3 enable ignores its direction bit");
   AST_REF_WRITE: assert property (
      wr_ok && paddr == 12'h27c |=> ref_value == $past(pwdata[3:0]) && ref_enable == $past(pwdata[7]))
      else $error("reference write not applied");
   AST_REF_HOLD: assert property (
      !(wr_ok && paddr == 12'h27c) |=> $stable(ref_value) && $stable(ref_enable) && $stable(ref_pin_connect))
      else $error("reference changed without its own write");
   AST_RESET_CLEAR: assert property (
      $rose(presetn) |-> !ref_enable && !ref_pin_connect && !ref_range_select && ref_value == 4'h0)
      else $error("reference not cleared by reset");
   AST_PIN2_ROUTE: assert property (
      ref_to_port_a_pin2 |-> ref_pin_connect)
      else $error("reference routed without pin connect");
   AST_IRQ_OFF: assert property (
      wr_ok && paddr == 12'h230 && !pwdata[6] |=> !cmp_irq_request)
      else $error("request stays with enable cleared");

   // Main scenarios.
   cover property (cmp_mode_field == 3'h6 && port_a_pin3_oe);
   cover property ($rose(cmp_irq_request));
   cover property (ref_to_port_a_pin2);
endmodule // cmp_vref_monitor

// ===== analog_side_model.sv
`timescale 1ns/1ps

// Stands in for the two comparators and the port A pin levels.
module analog_side_model #(
   parameter int resp_cycles = 2
) (
   // Clock.
   input wire logic pclk,
   // Levels seen by the block.
   output logic [1:0] cmp_raw_result,
   output logic [4:0] port_a_pin_in
);
   initial
   begin
      cmp_raw_result = 2'h0;
      port_a_pin_in = 5'h00;
   end

   // A comparator settles only after its response time; extra models a slow one.
   task automatic set_cmp(input logic [1:0] c, input int extra);
      repeat (resp_cycles + extra) @(posedge pclk);
      cmp_raw_result <= c;
   endtask

   // Pin levels move just after an edge.
   task automatic set_pins(input logic [4:0] p);
      @(posedge pclk);
      port_a_pin_in <= p;
   endtask
endmodule // analog_side_model

// ===== tb_top.sv
`timescale 1ns/1ps
`include "cmp_vref_defines.svh"

module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'h1;
   logic pready, pslverr, port_a_pin3_out, port_a_pin3_oe, port_a_pin4_out, port_a_pin4_oe;
   logic cmp_input_switch, ref_enable, ref_pin_connect, ref_range_select;
   logic ref_to_port_a_pin2, cmp_irq_request;
   logic [1:0] cmp_raw_result;
   logic [2:0] cmp_mode_field;
   logic [3:0] ref_value;
   logic [4:0] port_a_pin_in, port_a_analog, pins;
   logic [4:0] port_a_latch = 5'h0a;
   logic [31:0] expq [$];
   logic err_exp = 1'b0;
   int seed = 32'he3a1;
   int mismatches = 0;
   int cmp_count = 0;

   always #10 pclk = ~pclk;

   cmp_vref_control #(.addr_width(12)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmp_raw_result, .port_a_pin_in,
      .port_a_latch, .port_a_pin3_out, .port_a_pin3_oe, .port_a_pin4_out, .port_a_pin4_oe,
      .port_a_analog, .cmp_mode_field, .cmp_input_switch, .ref_enable, .ref_pin_connect,
      .ref_range_select, .ref_value, .ref_to_port_a_pin2, .cmp_irq_request);

   analog_side_model model (.pclk, .cmp_raw_result, .port_a_pin_in);

   // Register index to APB byte address.
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the idle edge first keeps back-to-back calls race free.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the access phase until pready is seen high at a rising edge.
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'b1, ba(i), {24'h0, d});
   endtask

   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      expq.push_back({24'h0, e});
      xfer(1'b0, ba(i), 32'h0);
   endtask

   // Every completed transfer answers with the error response its address calls for.
   always @(posedge pclk)
      if (psel && penable && pready)
         chk(32'(pslverr), 32'(err_exp));

   // Each completed read takes the oldest expected word off the queue.
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && expq.size() > 0)
         chk(prdata, expq.pop_front());

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The whole sequence needs a few hundred cycles; this allows ten thousand.
   initial
   begin
      #200us;
      mismatches++;
      give_verdict();
   end

   initial
   begin
      logic [15:0] rst_tab [6] = '{16'h0b00, 16'h0c00, 16'h1f00, 16'h851f, 16'h8c00, 16'h9f00};
      logic [2:0] modes [4] = '{3'h7, 3'h6, 3'h5, 3'h2};
      logic [4:0] amask [4] = '{5'h00, 5'h07, 5'h03, 5'h0f};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_tab[k]) rd(rst_tab[k][15:8], rst_tab[k][7:0]);
      wr(`IDX_REFERENCE_CONTROL, 8'hff);
      wr(`IDX_COMPARATOR_CONTROL, 8'hcf);
      #1 chk({28'h0, cmp_input_switch, cmp_mode_field}, 32'hf);
      rd(`IDX_REFERENCE_CONTROL, 8'hef);
      rd(`IDX_COMPARATOR_CONTROL, 8'h0f);
      wr(`IDX_PERIPH_IRQ_FLAGS, 8'hff);
      rd(`IDX_PERIPH_IRQ_FLAGS, 8'h40);
      wr(`IDX_PERIPH_IRQ_FLAGS, 8'h00);
      rd(`IDX_PERIPH_IRQ_FLAGS, 8'h00);
      wr(`IDX_PERIPH_IRQ_ENABLES, 8'h40);
      model.set_cmp(2'b01, 0);
      repeat (6) @(posedge pclk);
      #1 chk(32'(cmp_irq_request), 32'h1);
      rd(`IDX_PERIPH_IRQ_FLAGS, 8'h40);
      rd(`IDX_COMPARATOR_CONTROL, 8'h4f);
      wr(`IDX_PERIPH_IRQ_FLAGS, 8'h00);
      #1 chk(32'(cmp_irq_request), 32'h0);
      model.set_cmp(2'b11, 3);
      repeat (8) @(posedge pclk);
      #1 chk(32'(cmp_irq_request), 32'h1);
      wr(`IDX_PERIPH_IRQ_ENABLES, 8'h00);
      #1 chk(32'(cmp_irq_request), 32'h0);
      wr(`IDX_COMPARATOR_CONTROL, 8'h06);
      wr(`IDX_PORT_A_DIRECTION, 8'h00);
      wr(`IDX_PERIPH_IRQ_FLAGS, 8'h00);
      model.set_cmp(2'b10, 0);
      repeat (2) @(posedge pclk);
      #1 chk({28'h0, port_a_pin4_out, port_a_pin3_out, port_a_pin4_oe, port_a_pin3_oe}, 32'hb);
      wr(`IDX_PORT_A_DIRECTION, 8'h08);
      #1 chk({30'h0, port_a_pin4_oe, port_a_pin3_oe}, 32'h2);
      rd(`IDX_PERIPH_IRQ_FLAGS, 8'h40);
      for (int k = 0; k < 4; k++)
      begin
         pins = 5'($random(seed));
         port_a_latch <= 5'($random(seed));
         model.set_pins(pins);
         wr(`IDX_COMPARATOR_CONTROL, {5'h00, modes[k]});
         repeat (2) @(posedge pclk);
         #1 chk({27'h0, port_a_analog}, {27'h0, amask[k]});
         rd(`IDX_PORT_A_DATA, {3'h0, pins & ~amask[k]});
      end
      wr(`IDX_PORT_A_DIRECTION, 8'h04);
      wr(`IDX_REFERENCE_CONTROL, 8'h40);
      #1 chk(32'(ref_to_port_a_pin2), 32'h1);
      wr(`IDX_PORT_A_DIRECTION, 8'h00);
      #1 chk(32'(ref_to_port_a_pin2), 32'h0);
      wr(`IDX_REFERENCE_CONTROL, 8'ha6);
      rd(`IDX_REFERENCE_CONTROL, 8'ha6);
      err_exp <= 1'b1;
      rd(8'h00, 8'h00);
      err_exp <= 1'b0;
      wr(`IDX_REFERENCE_CONTROL, 8'h26);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`IDX_REFERENCE_CONTROL, 8'h00);
      rd(`IDX_PORT_A_DIRECTION, 8'h1f);
      rd(`IDX_PERIPH_IRQ_FLAGS, 8'h00);
      repeat (2) @(posedge pclk);
      give_verdict();
   end
endmodule // tb_top

bind cmp_vref_control cmp_vref_monitor #(.addr_width(addr_width)) mon (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .cmp_raw_result,
   .port_a_latch, .port_a_pin3_out, .port_a_pin3_oe, .port_a_pin4_out, .cmp_mode_field,
   .ref_enable, .ref_pin_connect, .ref_range_select, .ref_value, .ref_to_port_a_pin2,
   .cmp_irq_request);
